// File: rtl/ckss_pkg.sv
/*
  constants and helpers shared by the clock speed select block.
  assumes a 32-bit apb register bus, one register per aligned word.
*/
package ckss_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CKSS_IDX_SPEED_CTRL  = 8'h8F;
  localparam logic [7:0] CKSS_IDX_SECOND_CTRL = 8'hAF;
  localparam logic [7:0] CKSS_IDX_RELOAD      = 8'h97;
  localparam logic [7:0] CKSS_IDX_OSC_CTRL    = 8'h86;
  localparam logic [7:0] CKSS_IDX_STATUS      = 8'h98;

  // clock_speed_control field positions
  localparam int unsigned CKSS_BIT_DOUBLE_SPEED = 0;
  localparam int unsigned CKSS_BIT_TIMER0_FAST  = 1;
  localparam int unsigned CKSS_BIT_TIMER1_FAST  = 2;
  localparam int unsigned CKSS_BIT_TIMER2_FAST  = 3;
  localparam int unsigned CKSS_BIT_UART_FAST    = 4;
  localparam int unsigned CKSS_BIT_CNTARR_FAST  = 5;
  localparam int unsigned CKSS_BIT_WDOG_FAST    = 6;
  localparam int unsigned CKSS_BIT_TWOWIRE_FAST = 7;
  // second_clock_control and oscillator_control_reg fields
  localparam int unsigned CKSS_BIT_SPI_FAST     = 0;
  localparam int unsigned CKSS_BIT_OSC_SELECT   = 0;
  localparam int unsigned CKSS_BIT_TMR0_SUBCLK  = 1;

  // values after reset
  localparam logic [6:0] CKSS_SPEED_UPPER_RST  = 7'h00;
  localparam logic [7:0] CKSS_SECOND_CTRL_RST  = 8'h00;
  localparam logic [7:0] CKSS_RELOAD_RST       = 8'hFF;
  localparam logic [7:0] CKSS_OSC_CTRL_RST     = 8'h01;

  // prescaler bypass value and phase generator counts
  localparam logic [7:0] CKSS_RELOAD_BYPASS    = 8'hFF;
  localparam logic [3:0] CKSS_PHASE_HALF_LAST  = 4'h5;
  localparam logic [3:0] CKSS_PHASE_LAST       = 4'hB;
  localparam logic [1:0] CKSS_UART_MODE0       = 2'h0;
  localparam logic [1:0] CKSS_UART_MODE2       = 2'h2;

  function automatic logic [11:0] ckss_reg_addr(input logic [7:0] idx);
    ckss_reg_addr = {2'b00, idx, 2'b00};
  endfunction : ckss_reg_addr

  // last count of a 2*(255-reload) source tick period
  function automatic logic [8:0] ckss_div_last(input logic [7:0] reload);
    ckss_div_last = {(CKSS_RELOAD_BYPASS - reload), 1'b0} - 9'h001;
  endfunction : ckss_div_last

  // peripheral cycle strobe: fast bit honoured in double speed only, cleared = fast
  function automatic logic ckss_periph_en(input logic dbl, input logic slow_bit,
                                          input logic c6, input logic c12);
    ckss_periph_en = dbl ? (slow_bit ? c12 : c6) : c6;
  endfunction : ckss_periph_en

endpackage : ckss_pkg

// File: rtl/ckss_prescaler.sv
/*
  reload prescaler: passes one tick in every 2*(255-reload) source ticks, and every source tick at reload 255.
  assumes tick_in is a one-cycle strobe on ref_clk_in.
*/
`timescale 1ns/100ps
module ckss_prescaler
  import ckss_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       tick_in,
  input  wire logic [7:0] reload_in,
  output logic            tick_out
);

  logic [8:0] count_r;
  logic [8:0] count_nxt;
  logic       tick_nxt;

  wire bypass  = (reload_in == CKSS_RELOAD_BYPASS);
  // >= keeps a raised reload (shorter period) from running past its period
  wire at_last = (count_r >= ckss_div_last(reload_in));

  always_comb begin
    count_nxt = count_r;
    if (bypass) begin
      count_nxt = 9'h000;
    end else if (tick_in) begin
      count_nxt = at_last ? 9'h000 : count_r + 9'h001;
    end
  end

  assign tick_nxt = tick_in & (bypass | at_last);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      count_r  <= 9'h000;
      tick_out <= 1'b0;
    end else begin
      count_r  <= count_nxt;
      tick_out <= tick_nxt;
    end
  end

endmodule : ckss_prescaler

// File: rtl/ckss_sync.sv
/*
  two flip-flop synchroniser for a group of pin levels.
  assumes the inputs are asynchronous levels; no logic reads stage one.
*/
`timescale 1ns/100ps
module ckss_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      stage1_r <= '0;
      sync_out <= '0;
    end else begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule : ckss_sync

// File: rtl/ckss_top.sv
/*
  clock speed select: oscillator select, reload prescaler, half-rate stage,
  phase generator and per-peripheral cycle strobes, with apb registers.
  assumes oscillator and timer0 pins are asynchronous and far slower than
  ref_clk_in; uart mode and security strap come from logic on this clock.
*/
`timescale 1ns/100ps
module ckss_top
  import ckss_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        main_oscillator_in,
  input  wire logic        sub_oscillator_in,
  input  wire logic        timer0_ext_input_in,
  input  wire logic        hw_security_double_in,
  input  wire logic [1:0]  uart_mode_in,
  output logic             core_tick_out,
  output logic             cpu_cycle_out,
  output logic             timer0_en_out,
  output logic             timer1_en_out,
  output logic             timer2_en_out,
  output logic             uart_en_out,
  output logic             counter_array_en_out,
  output logic             watchdog_en_out,
  output logic             two_wire_en_out,
  output logic             spi_en_out,
  output logic             timer0_clk_out,
  output logic             double_speed_active_out
);

  // pin synchronisation and edge detection
  logic [2:0] pins_sync;
  logic [2:0] pins_prev_r;

  ckss_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({timer0_ext_input_in, sub_oscillator_in, main_oscillator_in}),
    .sync_out   (pins_sync)
  );

  wire [2:0] pins_rise = pins_sync & ~pins_prev_r;
  wire       main_rise = pins_rise[0];
  wire       sub_rise  = pins_rise[1];
  wire       tmr0_rise = pins_rise[2];

  // registers
  logic [7:0] speed_ctrl_r;
  logic [7:0] second_ctrl_r;
  logic [7:0] reload_r;
  logic [7:0] osc_ctrl_r;
  logic       double_active_r;
  logic       half_r;
  logic [3:0] phase_r;
  logic [3:0] phase_nxt;

  wire double_req   = speed_ctrl_r[CKSS_BIT_DOUBLE_SPEED];
  wire osc_select   = osc_ctrl_r[CKSS_BIT_OSC_SELECT];
  wire tmr0_sub_sel = osc_ctrl_r[CKSS_BIT_TMR0_SUBCLK];

  // apb decode
  wire access     = psel_in & penable_in;
  wire first_acc  = access & ~pready_out;
  wire done       = access & pready_out;
  wire wr_done    = done & pwrite_in;
  wire hit_speed  = (paddr_in == ckss_reg_addr(CKSS_IDX_SPEED_CTRL));
  wire hit_second = (paddr_in == ckss_reg_addr(CKSS_IDX_SECOND_CTRL));
  wire hit_reload = (paddr_in == ckss_reg_addr(CKSS_IDX_RELOAD));
  wire hit_osc    = (paddr_in == ckss_reg_addr(CKSS_IDX_OSC_CTRL));
  wire hit_status = (paddr_in == ckss_reg_addr(CKSS_IDX_STATUS));
  wire mapped     = hit_speed | hit_second | hit_reload | hit_osc | hit_status;
  wire [7:0] status_val = {7'h00, double_active_r};
  wire [7:0] rd_byte = ({8{hit_speed}} & speed_ctrl_r)
                     | ({8{hit_second}} & second_ctrl_r)
                     | ({8{hit_reload}} & reload_r)
                     | ({8{hit_osc}} & osc_ctrl_r)
                     | ({8{hit_status}} & status_val);

  // oscillator select and prescaler
  wire osc_tick = osc_select ? main_rise : sub_rise;
  wire pre_tick;

  ckss_prescaler u_prescaler (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .tick_in    (osc_tick),
    .reload_in  (reload_r),
    .tick_out   (pre_tick)
  );

  // half-rate stage and double speed switch point
  wire half_edge = pre_tick & ~half_r;
  wire core_tick = double_active_r ? pre_tick : half_edge;

  // phase generator: 6 core ticks per machine cycle
  wire phase_wrap = (phase_r == CKSS_PHASE_LAST);
  wire c6         = core_tick & ((phase_r == CKSS_PHASE_HALF_LAST) | phase_wrap);
  wire c12        = core_tick & phase_wrap;
  assign phase_nxt = core_tick ? (phase_wrap ? 4'h0 : phase_r + 4'h1) : phase_r;

  // per-peripheral strobes
  wire uart_fast_mode = (uart_mode_in == CKSS_UART_MODE0) | (uart_mode_in == CKSS_UART_MODE2);
  wire uart_slow_bit  = speed_ctrl_r[CKSS_BIT_UART_FAST] | ~uart_fast_mode;
  wire tmr0_en = ckss_periph_en(double_active_r, speed_ctrl_r[CKSS_BIT_TIMER0_FAST], c6, c12);
  wire t1_en   = ckss_periph_en(double_active_r, speed_ctrl_r[CKSS_BIT_TIMER1_FAST], c6, c12);
  wire t2_en   = ckss_periph_en(double_active_r, speed_ctrl_r[CKSS_BIT_TIMER2_FAST], c6, c12);
  wire uart_en = ckss_periph_en(double_active_r, uart_slow_bit, c6, c12);
  wire ca_en   = ckss_periph_en(double_active_r, speed_ctrl_r[CKSS_BIT_CNTARR_FAST], c6, c12);
  wire wd_en   = ckss_periph_en(double_active_r, speed_ctrl_r[CKSS_BIT_WDOG_FAST], c6, c12);
  wire tw_en   = ckss_periph_en(double_active_r, speed_ctrl_r[CKSS_BIT_TWOWIRE_FAST], c6, c12);
  wire spi_en  = ckss_periph_en(double_active_r, second_ctrl_r[CKSS_BIT_SPI_FAST], c6, c12);
  wire tmr0_clk = tmr0_sub_sel ? sub_rise : tmr0_rise;

  // apb slave: answer on the second access-phase edge
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= first_acc;
      pslverr_out <= first_acc & ~mapped;
      if (first_acc) begin
        prdata_out <= {24'h00_0000, rd_byte};
      end
    end
  end

  // software registers; strap loads double speed at reset
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      speed_ctrl_r  <= {CKSS_SPEED_UPPER_RST, hw_security_double_in};
      second_ctrl_r <= CKSS_SECOND_CTRL_RST;
      reload_r      <= CKSS_RELOAD_RST;
      osc_ctrl_r    <= CKSS_OSC_CTRL_RST;
    end else if (wr_done) begin
      if (hit_speed) begin
        speed_ctrl_r <= pwdata_in[7:0];
      end
      if (hit_second) begin
        second_ctrl_r <= {7'h00, pwdata_in[CKSS_BIT_SPI_FAST]};
      end
      if (hit_reload) begin
        reload_r <= pwdata_in[7:0];
      end
      if (hit_osc) begin
        osc_ctrl_r <= {6'h00, pwdata_in[1:0]};
      end
    end
  end

  // clock generation state
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pins_prev_r     <= 3'h0;
      double_active_r <= hw_security_double_in;
      half_r          <= 1'b0;
      phase_r         <= 4'h0;
    end else begin
      pins_prev_r <= pins_sync;
      if (pre_tick) begin
        half_r <= ~half_r;
      end
      if (half_edge) begin
        double_active_r <= double_req;
      end
      phase_r <= phase_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      core_tick_out           <= 1'b0;
      cpu_cycle_out           <= 1'b0;
      timer0_en_out           <= 1'b0;
      timer1_en_out           <= 1'b0;
      timer2_en_out           <= 1'b0;
      uart_en_out             <= 1'b0;
      counter_array_en_out    <= 1'b0;
      watchdog_en_out         <= 1'b0;
      two_wire_en_out         <= 1'b0;
      spi_en_out              <= 1'b0;
      timer0_clk_out          <= 1'b0;
      double_speed_active_out <= 1'b0;
    end else begin
      core_tick_out           <= core_tick;
      cpu_cycle_out           <= c6;
      timer0_en_out           <= tmr0_en;
      timer1_en_out           <= t1_en;
      timer2_en_out           <= t2_en;
      uart_en_out             <= uart_en;
      counter_array_en_out    <= ca_en;
      watchdog_en_out         <= wd_en;
      two_wire_en_out         <= tw_en;
      spi_en_out              <= spi_en;
      timer0_clk_out          <= tmr0_clk;
      double_speed_active_out <= double_active_r;
    end
  end

  // checks
  dbl_switch_edge_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $changed(double_active_r) |-> $past(half_edge))
    else $error("double speed changed off the half-rate edge");

  std_half_rate_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (!double_active_r && pre_tick && half_r) |=> !core_tick_out)
    else $error("standard mode passed a tick the half stage should drop");

  dbl_full_rate_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (double_active_r && pre_tick) |=> core_tick_out)
    else $error("double speed dropped a prescaler tick");

  periph_std_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (!double_active_r && c6) |=> (timer1_en_out && watchdog_en_out && spi_en_out))
    else $error("standard mode peripheral strobe missing");

  fast_bit_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (double_active_r && speed_ctrl_r[CKSS_BIT_TIMER0_FAST] && c6 && !c12) |=> !timer0_en_out)
    else $error("set fast bit did not select the slow strobe");

  uart_mode_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (double_active_r && !uart_fast_mode && c6 && !c12) |=> !uart_en_out)
    else $error("uart fast clock applied outside modes 0 and 2");

  tmr0_source_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (tmr0_sub_sel && sub_rise) |=> timer0_clk_out)
    else $error("timer0 did not follow the sub clock");

  strap_load_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> (double_active_r == $past(hw_security_double_in)) && (reload_r == CKSS_RELOAD_RST))
    else $error("reset did not load strap and reload");

  speed_write_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_done && hit_speed) |=> (speed_ctrl_r == $past(pwdata_in[7:0])))
    else $error("speed control write lost");

  cycle_six_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    c6 |-> (phase_r == CKSS_PHASE_HALF_LAST) || (phase_r == CKSS_PHASE_LAST))
    else $error("machine cycle strobe off its phase");

  spi_fast_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (double_active_r && !second_ctrl_r[CKSS_BIT_SPI_FAST] && c6) |=> spi_en_out)
    else $error("cleared spi bit did not select the fast strobe");

  wdog_slow_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (double_active_r && speed_ctrl_r[CKSS_BIT_WDOG_FAST] && c6 && !c12) |=> !watchdog_en_out)
    else $error("watchdog bit not at its field position");

  twowire_fast_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (double_active_r && !speed_ctrl_r[CKSS_BIT_TWOWIRE_FAST] && c6) |=> two_wire_en_out)
    else $error("two-wire bit not at its field position");

  osc_main_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (osc_select && main_rise && (reload_r == CKSS_RELOAD_BYPASS)) |=> pre_tick)
    else $error("main oscillator edge did not reach the prescaler");

  osc_sub_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (!osc_select && !sub_rise) |=> !pre_tick)
    else $error("prescaler ticked without a secondary oscillator edge");

  apb_pulse_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    pready_out |=> !pready_out)
    else $error("register answer held longer than one cycle");

endmodule : ckss_top

// File: tb/ckss_top_bench.sv
/*
  self-checking bench for the clock speed select block: apb register tasks,
  oscillator pin pulses and strobe period counts.
  assumes pins far slower than ref_clk; every wait is bounded.
*/
`timescale 1ns/100ps
module ckss_top_bench
  import ckss_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  pins    = 3'h0;
  logic        strap   = 1'b0;
  logic [1:0]  uart_mode = 2'h0;
  logic [10:0] mon;
  logic        dbl_act;
  int          hits [11];
  int          failures = 0;
  int          total_checks = 0;

  always #4 ref_clk = ~ref_clk;

  ckss_top u_dut (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .main_oscillator_in(pins[0]),
    .timer0_ext_input_in(pins[1]), .sub_oscillator_in(pins[2]),
    .hw_security_double_in(strap), .uart_mode_in(uart_mode),
    .core_tick_out(mon[0]), .cpu_cycle_out(mon[1]), .timer0_en_out(mon[2]),
    .timer1_en_out(mon[3]), .timer2_en_out(mon[4]), .uart_en_out(mon[5]),
    .counter_array_en_out(mon[6]), .watchdog_en_out(mon[7]), .two_wire_en_out(mon[8]),
    .spi_en_out(mon[9]), .timer0_clk_out(mon[10]), .double_speed_active_out(dbl_act)
  );

  // strobe counters
  always @(posedge ref_clk) begin
    for (int i = 0; i < 11; i++) begin
      if (mon[i] === 1'b1) hits[i] <= hits[i] + 1;
    end
  end

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic timeout();
    failures++;
    $display("timeout at t=%0t", $time);
    wrap_up();
  endtask : timeout

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask : do_reset

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    int k;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
      if (k > 20) timeout();
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd, input logic ee);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic ee);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0000_0000, d, e);
    chk(d, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask : rd

  task automatic pulses(input int pin, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      pins[pin] <= 1'b1;
      repeat (5) @(posedge ref_clk);
      pins[pin] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask : pulses

  // pin edges between two strobes, phase independent
  task automatic period(input int idx, input int pin, input int exp);
    int h;
    int n;
    h = hits[idx];
    n = 0;
    while (hits[idx] == h) begin
      pulses(pin, 1);
      n++;
      if (n > 2000) timeout();
    end
    h = hits[idx];
    n = 0;
    while (hits[idx] == h) begin
      pulses(pin, 1);
      n++;
      if (n > 2000) timeout();
    end
    chk(32'(n), 32'(exp));
  endtask : period

  task automatic quiet(input int idx, input int pin, input int n);
    int h;
    h = hits[idx];
    pulses(pin, n);
    chk(32'(hits[idx] - h), 32'h0000_0000);
  endtask : quiet

  initial begin
    do_reset(1'b0);
    rd(CKSS_IDX_SPEED_CTRL, 32'h0000_0000, 1'b0);
    rd(CKSS_IDX_SECOND_CTRL, 32'h0000_0000, 1'b0);
    rd(CKSS_IDX_RELOAD, 32'h0000_00FF, 1'b0);
    rd(CKSS_IDX_OSC_CTRL, 32'h0000_0001, 1'b0);
    rd(8'h01, 32'h0000_0000, 1'b1);
    wr(8'h01, 32'h0000_00FF, 1'b1);
    wr(CKSS_IDX_STATUS, 32'h0000_0001, 1'b0);
    rd(CKSS_IDX_STATUS, 32'h0000_0000, 1'b0);
    wr(CKSS_IDX_SPEED_CTRL, 32'h0000_00FE, 1'b0);
    rd(CKSS_IDX_SPEED_CTRL, 32'h0000_00FE, 1'b0);
    wr(CKSS_IDX_SECOND_CTRL, 32'h0000_0001, 1'b0);
    rd(CKSS_IDX_SECOND_CTRL, 32'h0000_0001, 1'b0);
    $display("registers test done");
    pulses(0, 8);
    period(0, 0, 2);
    period(1, 0, 12);
    for (int i = 2; i < 10; i++) period(i, 0, 12);
    $display("standard mode test done");
    wr(CKSS_IDX_SPEED_CTRL, 32'h0000_0001, 1'b0);
    wr(CKSS_IDX_SECOND_CTRL, 32'h0000_0000, 1'b0);
    repeat (20) @(posedge ref_clk);
    chk({31'h0, dbl_act}, 32'h0000_0000);
    pulses(0, 4);
    chk({31'h0, dbl_act}, 32'h0000_0001);
    rd(CKSS_IDX_STATUS, 32'h0000_0001, 1'b0);
    pulses(0, 8);
    period(0, 0, 1);
    period(1, 0, 6);
    for (int i = 2; i < 10; i++) period(i, 0, 6);
    @(posedge ref_clk);
    uart_mode <= 2'h1;
    period(5, 0, 12);
    @(posedge ref_clk);
    uart_mode <= 2'h2;
    period(5, 0, 6);
    for (int b = 1; b < 8; b++) begin
      wr(CKSS_IDX_SPEED_CTRL, 32'h0000_0001 | (32'h0000_0001 << b), 1'b0);
      period(b + 1, 0, 12);
      period((b == 1) ? 3 : 2, 0, 6);
    end
    wr(CKSS_IDX_SPEED_CTRL, 32'h0000_00FF, 1'b0);
    wr(CKSS_IDX_SECOND_CTRL, 32'h0000_0001, 1'b0);
    pulses(0, 4);
    for (int i = 2; i < 10; i++) period(i, 0, 12);
    $display("double speed test done");
    wr(CKSS_IDX_SPEED_CTRL, 32'h0000_0001, 1'b0);
    wr(CKSS_IDX_RELOAD, 32'h0000_00FD, 1'b0);
    pulses(0, 16);
    period(0, 0, 4);
    wr(CKSS_IDX_SPEED_CTRL, 32'h0000_0000, 1'b0);
    pulses(0, 32);
    chk({31'h0, dbl_act}, 32'h0000_0000);
    period(0, 0, 8);
    $display("reload test done");
    wr(CKSS_IDX_RELOAD, 32'h0000_00FF, 1'b0);
    wr(CKSS_IDX_OSC_CTRL, 32'h0000_0001, 1'b0);
    period(10, 1, 1);
    quiet(10, 2, 4);
    wr(CKSS_IDX_OSC_CTRL, 32'h0000_0003, 1'b0);
    period(10, 2, 1);
    quiet(10, 1, 4);
    wr(CKSS_IDX_OSC_CTRL, 32'h0000_0000, 1'b0);
    pulses(2, 8);
    period(0, 2, 2);
    quiet(0, 0, 6);
    $display("clock source test done");
    do_reset(1'b1);
    rd(CKSS_IDX_SPEED_CTRL, 32'h0000_0001, 1'b0);
    chk({31'h0, dbl_act}, 32'h0000_0001);
    $display("strap test done");
    wrap_up();
  end
endmodule : ckss_top_bench
